//--- ubc_chan_if.sv
/*
  interface carrying all five channels' conflict levels from the channel
  logic to the shared-vector router.
  assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface ubc_chan_if;
  logic [4:0] conflict;   // per-channel conflict request levels
  logic sel_a;            // choose channel 3 over 0 for vector a
  logic sel_b;            // choose channel 4 over 1 for vector b
  logic vec_a;            // shared request on vector a
  logic vec_b;            // shared request on vector b
  logic vec_c;            // request for channel 2
  modport src (output conflict, output sel_a, output sel_b, input vec_a, input vec_b,
    input vec_c);
  modport rtr (input conflict, input sel_a, input sel_b, output vec_a, output vec_b,
    output vec_c);
endinterface : ubc_chan_if

//--- ubc_checker.sv
/* port-level checker for the conflict-detect top.
   assumes the bit-rate divider keeps its reset value of 16 clocks a bit. */
`timescale 1ns/1ps
module ubc_checker (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [ubc_pkg::DATA_W-1:0] O_RDATA,
  input wire logic [ubc_pkg::NCH-1:0] I_OTHER_CONFLICT,
  input wire logic O_SERIAL_OUT_PIN,
  input wire logic O_SERIAL_CLOCK_PIN,
  input wire logic O_IRQ,
  input wire logic O_VEC_B,
  input wire logic O_VEC_C
);
  import ubc_pkg::*;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  logic [5:0] idle_q; // cycles the clock pin has stayed high
  logic [3:0] bits_q; // bit starts seen in the current frame
  // count idle time, and bit starts until the line has been idle long
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      idle_q <= 6'h00;
      bits_q <= 4'h0;
    end else begin
      idle_q <= !O_SERIAL_CLOCK_PIN ? 6'h00 : (idle_q == 6'h3f ? idle_q : idle_q + 6'h01);
      if ($fell(O_SERIAL_CLOCK_PIN)) bits_q <= bits_q + 4'h1;
      else if (idle_q == 6'h28) bits_q <= 4'h0;
    end
  end
  rdata_quiet_a: assert property (!$past(I_RD) |-> O_RDATA == '0)
    else $error("read data not zero outside a read");
  irq_fall_a: assert property ($fell(O_IRQ) |-> $past(I_RD) || $past(I_WR))
    else $error("interrupt dropped without a read or write");
  irq_rise_a: assert property ($rose(O_IRQ) |-> $past(I_WR) || $past(idle_q) < 6'h18)
    else $error("interrupt raised away from a frame");
  vec_c_a: assert property (O_VEC_C == $past(I_OTHER_CONFLICT[2]))
    else $error("third vector does not follow its channel");
  vec_b_a: assert property (O_VEC_B |->
    $past(I_OTHER_CONFLICT[1]) || $past(I_OTHER_CONFLICT[4]))
    else $error("second vector without a request of its pair");
  out_steady_a: assert property ($changed(O_SERIAL_OUT_PIN) |-> !O_SERIAL_CLOCK_PIN)
    else $error("serial output changed in the second half of a bit");
  bit_len_a: assert property ($fell(O_SERIAL_CLOCK_PIN) |-> ##9 O_SERIAL_CLOCK_PIN
    ##7 ($fell(O_SERIAL_CLOCK_PIN) || O_SERIAL_CLOCK_PIN))
    else $error("bit period is not sixteen clocks");
  frame_bits_a: assert property (idle_q == 6'h1e |->
    bits_q == 4'h0 || bits_q == 4'hb)
    else $error("frame did not hold eleven bits");
  frame_cov: cover property (idle_q == 6'h1e && bits_q == 4'hb);
  irq_cov: cover property ($rose(O_IRQ));
  vec_cov: cover property ($rose(O_VEC_B));
endmodule : ubc_checker
bind ubc_top ubc_checker ubc_checker_inst (.I_SYS_CLK, .I_RSTN, .I_WR, .I_RD, .O_RDATA,
  .I_OTHER_CONFLICT, .O_SERIAL_OUT_PIN, .O_SERIAL_CLOCK_PIN, .O_IRQ, .O_VEC_B, .O_VEC_C);

//--- ubc_line_model.sv
/* model of the other nodes on the shared serial line.
   assumes an open-drain wire with a pull-up. */
`timescale 1ns/1ps
module ubc_line_model (
  input wire logic i_tx,
  input wire logic i_pull_low,
  output logic o_line
);
  // wired-and: any node pulling low wins, else the pull-up holds high
  assign o_line = i_tx & ~i_pull_low;
endmodule : ubc_line_model

//--- ubc_pkg.sv
/*
  package for the multi-drop uart conflict-detect block: register offsets,
  field positions, reset values, frame constants and the state type.
  assumes a single 10 mhz system clock and a simple strobe register port.
*/
package ubc_pkg;
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [3:0] OFS_CTL = 4'h0;     // uart_ctl_one: tx enable
  localparam logic [3:0] OFS_SMR = 4'h1;     // special_mode_ctl
  localparam logic [3:0] OFS_TXD = 4'h2;     // transmit data, 9 bits
  localparam logic [3:0] OFS_BRG = 4'h3;     // bit-rate divider
  localparam logic [3:0] OFS_SEL = 4'h4;     // irq_source_select
  localparam logic [3:0] OFS_STAT = 4'h5;    // sticky status, read clears
  localparam logic [3:0] OFS_MASK = 4'h6;    // interrupt mask
  // control fields
  localparam int CTL_TE = 0;                 // tx_enable_flag
  localparam int CTL_BUSY = 1;               // read-only: frame in flight
  localparam int SMR_MODE = 0;               // multi-drop bus mode enable
  localparam int SMR_CONFLICT_SAMPLE_SELECT = 4;              // conflict_sample_select
  localparam int SMR_AUTO_TX_DISABLE_ON_CONFLICT = 5;               // auto_tx_disable_on_conflict
  localparam int SMR_SSS = 6;                // start_sync_select
  localparam int SMR_POL = 7;                // line_polarity_invert
  localparam int SEL_A = 6;                  // shared_vec_a_select
  localparam int SEL_B = 7;                  // shared_vec_b_select
  // status fields
  localparam int ST_CONF = 0;                // conflict irq_request_flag
  localparam int ST_DONE = 1;                // frame complete
  localparam int ST_W = 2;
  // reset values
  localparam logic [15:0] RST_BRG = 16'h000f;
  // frame: start, nine data, stop
  localparam int DATA_BITS = 9;
  localparam int FRAME_BITS = 11;
  localparam logic [3:0] LAST_BIT = 4'ha;
  // channel and vector numbers
  localparam int NCH = 5;
  localparam logic [7:0] VEC_A = 8'h28;      // shared by channels 0 and 3
  localparam logic [7:0] VEC_B = 8'h29;      // shared by channels 1 and 4
  // timer used for sampling per channel: 3,4,0,3,4
  localparam logic [14:0] TMR_OF_CH = {3'h4, 3'h3, 3'h0, 3'h4, 3'h3};
  // transmitter states, gray along idle->wait->send
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SEND = 2'b11
  } ubc_state_t;
endpackage : ubc_pkg

//--- ubc_top.sv
/*
  conflict detect and synchronised transmit start for one uart channel on
  a shared multi-drop serial line, with register port and interrupt.
  assumes synchronous pins, a timer underflow pulse from outside, and
  other nodes sharing the line.
*/
// Implementation choices: the register offsets and the strobed register port.
// Function
// RULE1: irq when driven and sampled levels differ
// RULE2: vectors 40/41 shared, selects pick channel
// RULE3: select 0: compare on transfer clock rise
// RULE4: select 1: compare on assigned timer underflow
// RULE5: software runs sampling timer one-shot, triggered
// RULE6: auto-clear bit clears tx enable on conflict
// RULE7: sync start: begin on input line edge
// RULE8: edge falling, or rising when polarity inverted
// RULE9: no sync: start one transfer clock later
// RULE10: frame is start, nine data lsb-first, stop
// RULE11: software writes port registers right after unlock
// RULE12: no interrupt or dma between unlock and write
// RULE13: logic active only in multi-drop bus mode; code gates only the conflict compare, sync start ignores the mode bit
// RULE14: compare only while transmitting a frame
`timescale 1ns/1ps
module ubc_top (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic [ubc_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [ubc_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [ubc_pkg::DATA_W-1:0] O_RDATA,
  input wire logic I_SERIAL_IN_PIN,
  input wire logic [ubc_pkg::NCH-1:0] I_TIMER_UFLOW,
  input wire logic [ubc_pkg::NCH-1:0] I_OTHER_CONFLICT,
  output logic O_SERIAL_OUT_PIN,
  output logic O_SERIAL_CLOCK_PIN,
  output logic O_IRQ,
  output logic O_VEC_A,
  output logic O_VEC_B,
  output logic O_VEC_C
);
  import ubc_pkg::*;

  // channel number this instance occupies within the five
  localparam int CH = 0;
  localparam logic [2:0] MY_TMR = TMR_OF_CH[3*CH +: 3];

  // registers
  logic te_d, te_q;                  // tx_enable_flag
  logic [7:0] smr_d, smr_q;          // special_mode_ctl
  logic [8:0] txd_d, txd_q;          // transmit data
  logic txv_d, txv_q;                // data waiting to send
  logic [15:0] brg_d, brg_q;         // bit-rate divider
  logic [7:0] sel_d, sel_q;          // irq_source_select
  logic [ST_W-1:0] stat_d, stat_q;   // sticky status
  logic [ST_W-1:0] mask_d, mask_q;   // interrupt mask
  logic [DATA_W-1:0] rdata_d, rdata_q;
  // transmitter
  ubc_state_t state_d, state_q;
  logic [15:0] div_d, div_q;         // bit-rate counter
  logic [3:0] bit_d, bit_q;          // frame bit index
  logic [10:0] shf_d, shf_q;         // frame shift register
  logic out_d, out_q;                // serial output level
  logic sclk_d, sclk_q;              // transfer clock level
  logic rx_d, rx_q;                  // previous input level, edge detect
  // events
  logic half_tick;                   // mid-bit: transfer clock rises
  logic bit_tick;                    // end of bit period
  logic sample;                      // conflict sampling instant
  logic conflict;                    // one-cycle conflict event
  logic start_edge;                  // selected input edge seen
  logic done_ev;                     // frame finished
  logic rd_stat;                     // status read clears
  logic [NCH-1:0] conf_vec;

  ubc_chan_if chan ();

  // combine this channel's sticky conflict status flag with the other channels' levels
  always_comb begin
    conf_vec = I_OTHER_CONFLICT;
    conf_vec[CH] = stat_q[ST_CONF];
  end
  assign chan.conflict = conf_vec;
  assign chan.sel_a = sel_q[SEL_A];
  assign chan.sel_b = sel_q[SEL_B];

  ubc_vec_route u_route (
    .i_clk(I_SYS_CLK),
    .i_rstn(I_RSTN),
    .bus(chan.rtr)
  );

  // timing events from the bit-rate counter
  always_comb begin
    bit_tick = (state_q == ST_SEND || state_q == ST_WAIT) && (div_q == brg_q);
    half_tick = (state_q == ST_SEND) && (div_q == {1'b0, brg_q[15:1]});
    // selected sampling instant, only mid-frame in bus mode
    if (smr_q[SMR_CONFLICT_SAMPLE_SELECT]) begin
      sample = I_TIMER_UFLOW[MY_TMR];  // [RULE4]
    end else begin
      sample = half_tick;  // [RULE3]
    end
    sample = sample && smr_q[SMR_MODE] && (state_q == ST_SEND);  // [RULE13] [RULE14]
    conflict = sample && (out_q != I_SERIAL_IN_PIN);  // [RULE1]
    // falling edge normally, rising edge with inverted polarity
    if (smr_q[SMR_POL]) begin
      start_edge = !rx_q && I_SERIAL_IN_PIN;  // [RULE8]
    end else begin
      start_edge = rx_q && !I_SERIAL_IN_PIN;  // [RULE8]
    end
    done_ev = (state_q == ST_SEND) && bit_tick && (bit_q == LAST_BIT);
    rd_stat = I_RD && (I_ADDR == OFS_STAT);
  end

  // transmitter next state
  always_comb begin
    state_d = state_q;
    div_d = div_q;
    bit_d = bit_q;
    shf_d = shf_q;
    out_d = out_q;
    sclk_d = sclk_q;
    rx_d = I_SERIAL_IN_PIN;
    case (state_q)
      ST_IDLE: begin
        out_d = 1'b1;
        sclk_d = 1'b1;
        div_d = 16'h0000;
        if (te_q && txv_q) begin
          // frame: stop, d8..d0, start, shifted out lsb first
          shf_d = {1'b1, txd_q, 1'b0};  // [RULE10]
          bit_d = 4'h0;
          if (smr_q[SMR_SSS]) begin
            state_d = ST_WAIT;  // [RULE7]
          end else begin
            state_d = ST_WAIT;  // [RULE9]
          end
        end
      end
      ST_WAIT: begin
        if (!te_q) begin
          state_d = ST_IDLE;
        end else if (smr_q[SMR_SSS]) begin
          // wait for the other node's edge, then start at once
          if (start_edge) begin
            state_d = ST_SEND;  // [RULE7]
            out_d = shf_d[0];
            sclk_d = 1'b0;  // transfer clock falls as the start bit begins
            div_d = 16'h0000;
          end
        end else if (bit_tick) begin
          // one transfer clock period after enable conditions
          state_d = ST_SEND;  // [RULE9]
          out_d = shf_q[0];
          sclk_d = 1'b0;  // transfer clock falls as the start bit begins
          div_d = 16'h0000;
        end else begin
          div_d = div_q + 16'h0001;
        end
      end
      ST_SEND: begin
        if (half_tick) begin
          sclk_d = 1'b1;
        end
        if (bit_tick) begin
          div_d = 16'h0000;
          sclk_d = 1'b0;
          if (bit_q == LAST_BIT) begin
            state_d = ST_IDLE;
            out_d = 1'b1;
            sclk_d = 1'b1;
          end else begin
            // next bit of the frame
            shf_d = {1'b1, shf_q[10:1]};  // [RULE10]
            out_d = shf_q[1];
            bit_d = bit_q + 4'h1;
          end
        end else begin
          div_d = div_q + 16'h0001;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // transmitter registers
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_q <= ST_IDLE;
      div_q <= 16'h0000;
      bit_q <= 4'h0;
      shf_q <= 11'h7ff;
      out_q <= 1'b1;
      sclk_q <= 1'b1;
      rx_q <= 1'b1;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      bit_q <= bit_d;
      shf_q <= shf_d;
      out_q <= out_d;
      sclk_q <= sclk_d;
      rx_q <= rx_d;
    end
  end

  // register file next values
  always_comb begin
    te_d = te_q;
    smr_d = smr_q;
    txd_d = txd_q;
    txv_d = txv_q;
    brg_d = brg_q;
    sel_d = sel_q;
    mask_d = mask_q;
    stat_d = stat_q;
    rdata_d = {DATA_W{1'b0}};
    // frame leaves the buffer when sending starts
    if (state_q == ST_WAIT && state_d == ST_SEND) begin
      txv_d = 1'b0;
    end
    if (I_WR) begin
      if (I_ADDR == OFS_CTL) begin
        te_d = I_WDATA[CTL_TE];
      end else if (I_ADDR == OFS_SMR) begin
        smr_d = I_WDATA[7:0];
      end else if (I_ADDR == OFS_TXD) begin
        txd_d = I_WDATA[DATA_BITS-1:0];
        txv_d = 1'b1;
      end else if (I_ADDR == OFS_BRG) begin
        brg_d = I_WDATA;
      end else if (I_ADDR == OFS_SEL) begin
        sel_d = I_WDATA[7:0];
      end else if (I_ADDR == OFS_MASK) begin
        mask_d = I_WDATA[ST_W-1:0];
      end
    end
    // conflict with auto-clear drops tx enable, beats a software write
    if (conflict && smr_q[SMR_AUTO_TX_DISABLE_ON_CONFLICT]) begin
      te_d = 1'b0;  // [RULE6]
    end
    // read clears; a new event in the same cycle stays set
    if (rd_stat) begin
      stat_d = {ST_W{1'b0}};
    end
    if (conflict) begin
      stat_d[ST_CONF] = 1'b1;  // [RULE1]
    end
    if (done_ev) begin
      stat_d[ST_DONE] = 1'b1;
    end
    if (I_RD) begin
      if (I_ADDR == OFS_CTL) begin
        rdata_d[CTL_TE] = te_q;
        rdata_d[CTL_BUSY] = (state_q != ST_IDLE);
      end else if (I_ADDR == OFS_SMR) begin
        rdata_d[7:0] = smr_q;
      end else if (I_ADDR == OFS_TXD) begin
        rdata_d[DATA_BITS-1:0] = txd_q;
      end else if (I_ADDR == OFS_BRG) begin
        rdata_d = brg_q;
      end else if (I_ADDR == OFS_SEL) begin
        rdata_d[7:0] = sel_q;
      end else if (I_ADDR == OFS_STAT) begin
        rdata_d[ST_W-1:0] = stat_q;
      end else if (I_ADDR == OFS_MASK) begin
        rdata_d[ST_W-1:0] = mask_q;
      end
    end
  end

  // register file flops
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      te_q <= 1'b0;
      smr_q <= 8'h00;
      txd_q <= 9'h000;
      txv_q <= 1'b0;
      brg_q <= RST_BRG;
      sel_q <= 8'h00;
      mask_q <= {ST_W{1'b0}};
      stat_q <= {ST_W{1'b0}};
      rdata_q <= {DATA_W{1'b0}};
    end else begin
      te_q <= te_d;
      smr_q <= smr_d;
      txd_q <= txd_d;
      txv_q <= txv_d;
      brg_q <= brg_d;
      sel_q <= sel_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs
  assign O_RDATA = rdata_q;
  assign O_SERIAL_OUT_PIN = out_q;
  assign O_SERIAL_CLOCK_PIN = sclk_q;
  assign O_IRQ = |(stat_q & mask_q);
  assign O_VEC_A = chan.vec_a;
  assign O_VEC_B = chan.vec_b;
  assign O_VEC_C = chan.vec_c;
endmodule : ubc_top

//--- ubc_top_bench.sv
/* self-checking bench for the conflict-detect top.
   assumes the line model stands between the output and input pins. */
`timescale 1ns/1ps
module ubc_top_bench;
  import ubc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [NCH-1:0] uflow = '0;
  logic [NCH-1:0] oconf = '0;
  logic pull = 1'b0; // another node pulling the line low
  logic [DATA_W-1:0] rdata;
  logic txo, sclk, irq, va, vb, vc, line;
  int fails = 0;
  int tests_run = 0;
  // 100 ns clock
  always #50 clk = ~clk;
  ubc_top ubc_top_inst (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SERIAL_IN_PIN(line), .I_TIMER_UFLOW(uflow),
    .I_OTHER_CONFLICT(oconf), .O_SERIAL_OUT_PIN(txo), .O_SERIAL_CLOCK_PIN(sclk),
    .O_IRQ(irq), .O_VEC_A(va), .O_VEC_B(vb), .O_VEC_C(vc));
  // pins meet the line directly: no port or write-protect setup stands between
  ubc_line_model ubc_line_model_inst (.i_tx(txo), .i_pull_low(pull), .o_line(line));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  // wait, bounded, until the clock pin marks a bit start
  task automatic wfall(input int lim, output int n);
    n = 0;
    while (sclk !== 1'b0 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wfall
  // sample each of the eleven bits near mid-bit, start bit first
  task automatic rx(input logic [8:0] d);
    int n;
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      wfall(20, n);
      repeat (6) @(posedge clk);
      #1 chk(16'(txo), 16'(f[i]));
      repeat (4) @(posedge clk);
    end
  endtask : rx
  task automatic t_regs;
    logic [15:0] d;
    rreg(OFS_BRG, d);
    chk(d, RST_BRG);
    wreg(4'h9, 16'hffff);
    rreg(4'h9, d);
    chk(d, 16'h0000);
    rreg(OFS_STAT, d);
    chk(d, 16'h0000);
  endtask : t_regs
  task automatic t_plain;
    int n;
    logic [15:0] d;
    wreg(OFS_SMR, 16'h0001);
    wreg(OFS_MASK, 16'h0003);
    wreg(OFS_CTL, 16'h0001);
    wreg(OFS_TXD, 16'h01a5);
    wfall(40, n);
    chk(16'(n > 14 && n < 20), 16'h0001);
    rx(9'h1a5);
    repeat (20) @(posedge clk);
    #1 chk(16'(irq), 16'h0001);
    wreg(OFS_MASK, 16'h0000);
    #1 chk(16'(irq), 16'h0000);
    wreg(OFS_MASK, 16'h0003);
    rreg(OFS_STAT, d);
    chk(d, 16'h0002);
    chk(16'(irq), 16'h0000);
  endtask : t_plain
  // another node holds the line low over the first data bits
  task automatic t_conf(input logic [15:0] smr, input logic [4:0] pm, input logic ec,
    input logic ete);
    int n;
    logic [15:0] d;
    wreg(OFS_SMR, smr);
    wreg(OFS_CTL, 16'h0001);
    wreg(OFS_TXD, 16'h01ff);
    wfall(40, n);
    @(posedge clk) pull <= 1'b1;
    repeat (40) @(posedge clk);
    uflow <= pm;
    @(posedge clk) uflow <= '0;
    @(posedge clk) pull <= 1'b0;
    repeat (200) @(posedge clk);
    rreg(OFS_STAT, d);
    chk(d & 16'h0001, 16'(ec));
    rreg(OFS_CTL, d);
    chk(d & 16'h0001, 16'(ete));
  endtask : t_conf
  // armed frame must wait for the chosen edge of the input line
  task automatic t_sync(input logic [15:0] smr, input logic p1);
    int n;
    logic [15:0] d;
    wreg(OFS_SMR, smr);
    wreg(OFS_CTL, 16'h0001);
    wreg(OFS_TXD, 16'h0155);
    @(posedge clk) pull <= p1;
    repeat (40) @(posedge clk);
    #1 chk(16'(sclk), 16'h0001);
    @(posedge clk) pull <= ~p1;
    wfall(5, n);
    chk(16'(n < 4), 16'h0001);
    @(posedge clk) pull <= 1'b0;
    repeat (200) @(posedge clk);
    rreg(OFS_STAT, d);
    // the line was pulled while waiting, which must not count as a conflict
    chk(d & 16'h0001, 16'h0000);
  endtask : t_sync
  // every select setting with channels 2, 3 and 4 requesting
  task automatic t_vec;
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      wreg(OFS_SEL, {8'h00, s, 6'h00});
      @(posedge clk) oconf <= 5'h1c;
      repeat (3) @(posedge clk);
      // vector a follows select bit 6, vector b select bit 7
      #1 chk(16'({va, vb, vc}), 16'({s[0], s[1], 1'b1}));
      @(posedge clk) oconf <= 5'h00;
      repeat (3) @(posedge clk);
      #1 chk(16'({va, vb, vc}), 16'h0000);
    end
  endtask : t_vec
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_plain;
    t_conf(16'h0021, 5'h00, 1'b1, 1'b0);
    t_conf(16'h0001, 5'h00, 1'b1, 1'b1);
    t_conf(16'h0011, 5'h10, 1'b0, 1'b1);
    t_conf(16'h0011, 5'h08, 1'b1, 1'b1);
    t_conf(16'h0020, 5'h00, 1'b0, 1'b1);
    t_sync(16'h0041, 1'b0);
    t_sync(16'h00c1, 1'b1);
    t_vec;
    give_verdict;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict;
  end
endmodule : ubc_top_bench

//--- ubc_vec_route.sv
/*
  router of channel conflict requests onto shared interrupt vectors.
  assumes levels synchronous to the system clock.
*/
`timescale 1ns/1ps
module ubc_vec_route (
  input wire logic i_clk,
  input wire logic i_rstn,
  ubc_chan_if.rtr bus
);
  import ubc_pkg::*;
  logic vec_a_d, vec_a_q;  // registered vector a request
  logic vec_b_d, vec_b_q;  // registered vector b request
  logic vec_c_d, vec_c_q;  // registered channel 2 request

  // pick one channel of each pair per source-select bit
  always_comb begin
    vec_a_d = bus.sel_a ? bus.conflict[3] : bus.conflict[0];  // [RULE2]
    vec_b_d = bus.sel_b ? bus.conflict[4] : bus.conflict[1];  // [RULE2]
    vec_c_d = bus.conflict[2];
  end

  // register the routed requests
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vec_a_q <= 1'b0;
      vec_b_q <= 1'b0;
      vec_c_q <= 1'b0;
    end else begin
      vec_a_q <= vec_a_d;
      vec_b_q <= vec_b_d;
      vec_c_q <= vec_c_d;
    end
  end

  assign bus.vec_a = vec_a_q;
  assign bus.vec_b = vec_b_q;
  assign bus.vec_c = vec_c_q;
endmodule : ubc_vec_route
